//--- logic/tofi2c_target.sv
// I2C target port with ranging handshake and shutdown boot
`timescale 1ns/10ps
module tofi2c_target #(
	parameter int BOOT_CYCLES  = tofi2c_pkg::BOOT_CYCLES,  // Boot wait
	parameter int RANGE_CYCLES = tofi2c_pkg::RANGE_CYCLES  // Ranging period
) (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset,
	// Power control
	input  wire logic       i_shutdown_n_input,
	// I2C lines
	input  wire logic       i_scl,
	output logic            o_scl_out,
	output logic            o_scl_oe,
	input  wire logic       i_sda,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	// Interrupt line
	output logic            o_ready_irq_output_out,
	output logic            o_ready_irq_output_oe,
	// Result source from the ranging core
	input  wire logic [15:0] i_result,
	// Status
	output logic [1:0]      o_power_state
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [1:0] scl_sync_q;     // SCL two-stage
	logic [1:0] sda_sync_q;     // SDA two-stage
	logic [1:0] shd_sync_q;     // Shutdown two-stage
	logic       scl_q;          // Previous synced SCL
	logic       sda_q;          // Previous synced SDA

	// Two flops on each of SCL, SDA and shutdown
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			shd_sync_q <= 2'h0;
			scl_q      <= 1'h1;
			sda_q      <= 1'h1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], i_scl};
			sda_sync_q <= {sda_sync_q[0], i_sda};
			shd_sync_q <= {shd_sync_q[0], i_shutdown_n_input};
			scl_q      <= scl_sync_q[1];
			sda_q      <= sda_sync_q[1];
		end
	end

	wire scl_s     = scl_sync_q[1];           // Synced SCL
	wire sda_s     = sda_sync_q[1];           // Synced SDA
	wire shd_n_s   = shd_sync_q[1];           // Synced shutdown
	wire scl_rise  = scl_s & ~scl_q;          // Sample point
	wire scl_fall  = ~scl_s & scl_q;          // Drive point
	wire start_det = scl_s & scl_q & sda_q & ~sda_s; // RULE5
	wire stop_det  = scl_s & scl_q & ~sda_q & sda_s; // RULE5

	// ------------------------------------------------------------
	// Power sequencing
	// ------------------------------------------------------------
	tofi2c_pkg::tofi_power_type pwr_q;        // Power state
	logic [31:0] boot_cnt_q;                  // Boot counter
	wire   awake = (pwr_q == tofi2c_pkg::TOFI_SW_STBY); // Bus usable

	// Standby, boot, then software standby
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			pwr_q      <= tofi2c_pkg::TOFI_HW_STBY;
			boot_cnt_q <= 32'h0;
		end else if (!shd_n_s) begin
			pwr_q      <= tofi2c_pkg::TOFI_HW_STBY;   // RULE19
			boot_cnt_q <= 32'h0;
		end else begin
			case (pwr_q)
				tofi2c_pkg::TOFI_HW_STBY: begin
					pwr_q <= tofi2c_pkg::TOFI_BOOT;
				end
				tofi2c_pkg::TOFI_BOOT: begin
					boot_cnt_q <= boot_cnt_q + 32'h1;
					if (boot_cnt_q >= 32'(BOOT_CYCLES - 1)) begin
						pwr_q <= tofi2c_pkg::TOFI_SW_STBY; // RULE20
					end
				end
				default: begin
					pwr_q <= tofi2c_pkg::TOFI_SW_STBY;
				end
			endcase
		end
	end
	assign o_power_state = pwr_q;

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	tofi2c_pkg::tofi_state_type st_q;          // Bus state
	logic [2:0]  bit_q;                        // Bit counter
	logic [7:0]  sh_q;                         // Serial/parallel register
	logic        rw_q;                         // Latched direction
	logic [1:0]  wcnt_q;                       // Write byte number
	logic [15:0] idx_q;                        // Current index
	logic        sda_drv_q;                    // Pull SDA low
	logic        wr_stb_q;                     // Store strobe
	logic [15:0] wr_idx_q;                     // Store address
	logic [7:0]  wr_dat_q;                     // Store data
	logic [7:0]  mem_q [tofi2c_pkg::STORE_DEPTH]; // Register storage
	logic        ready_q;                      // Result ready
	logic [15:0] res_q;                        // Held result
	logic        run_q;                        // Ranging enabled

	wire [7:0] rx_byte  = {sh_q[6:0], sda_s};  // Byte with last bit
	logic       full_q;                        // Eight bits taken since last byte end
	logic [7:0] rd_now;                        // Register at the current index

	// Register read decode
	function automatic logic [7:0] rd_reg(input logic [15:0] idx);
		if (idx == tofi2c_pkg::IDX_RESULT) begin
			rd_reg = res_q[15:8];                // RULE23
		end else if (idx == tofi2c_pkg::IDX_RESULT + 16'h1) begin
			rd_reg = res_q[7:0];
		end else if (idx == tofi2c_pkg::IDX_STATUS) begin
			rd_reg = {7'h0, ready_q};            // RULE15
		end else if (idx < 16'(tofi2c_pkg::STORE_DEPTH)) begin
			rd_reg = mem_q[idx[5:0]];
		end else begin
			rd_reg = 8'h0;
		end
	endfunction

	// Live read value, so that its top bit can be taken on its own
	always_comb begin
		rd_now = rd_reg(idx_q);
	end

	// Bus state machine
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			st_q      <= tofi2c_pkg::TOFI_IDLE;
			bit_q     <= 3'h0;
			sh_q      <= 8'h0;
			rw_q      <= 1'h0;
			wcnt_q    <= 2'h0;
			idx_q     <= 16'h0;
			sda_drv_q <= 1'h0;
			wr_stb_q  <= 1'h0;
			wr_idx_q  <= 16'h0;
			wr_dat_q  <= 8'h0;
			full_q    <= 1'h0;
		end else begin
			wr_stb_q <= 1'h0;
			if (!awake) begin
				st_q      <= tofi2c_pkg::TOFI_IDLE;     // RULE19
				sda_drv_q <= 1'h0;
				full_q    <= 1'h0;
			end else if (start_det) begin
				st_q      <= tofi2c_pkg::TOFI_ADDR;     // RULE6
				bit_q     <= 3'h0;
				sda_drv_q <= 1'h0;
				full_q    <= 1'h0;                      // Fall after a start ends no byte
			end else if (stop_det) begin
				st_q      <= tofi2c_pkg::TOFI_IDLE;     // RULE12 RULE25
				sda_drv_q <= 1'h0;
			end else begin
				case (st_q)
					tofi2c_pkg::TOFI_ADDR, tofi2c_pkg::TOFI_WRX: begin
						if (scl_rise) begin
							sh_q   <= rx_byte;            // RULE4
							bit_q  <= bit_q + 3'h1;
							full_q <= (bit_q == 3'h7);    // Eighth bit closes the byte
						end else if (scl_fall && full_q) begin
							// Byte complete, acknowledge slot begins
							full_q <= 1'h0;
							if (st_q == tofi2c_pkg::TOFI_ADDR) begin
								if (sh_q[7:1] == tofi2c_pkg::DEV_ADDR) begin // RULE1
									rw_q      <= sh_q[0];     // RULE2 RULE7
									wcnt_q    <= 2'h0;
									sda_drv_q <= 1'h1;
									st_q      <= tofi2c_pkg::TOFI_AACK;
								end else begin
									st_q <= tofi2c_pkg::TOFI_IDLE;
								end
							end else begin
								sda_drv_q <= 1'h1;            // RULE3 RULE9
								st_q      <= tofi2c_pkg::TOFI_WACK;
								if (wcnt_q == 2'h0) begin
									idx_q[15:8] <= sh_q;      // RULE8
									wcnt_q      <= 2'h1;
								end else if (wcnt_q == 2'h1) begin
									idx_q[7:0] <= sh_q;
									wcnt_q     <= 2'h2;
								end else begin
									wr_stb_q <= 1'h1;         // RULE9
									wr_idx_q <= idx_q;
									wr_dat_q <= sh_q;
									idx_q    <= idx_q + 16'h1; // RULE13
								end
							end
						end
					end
					tofi2c_pkg::TOFI_AACK: begin
						if (scl_fall) begin
							if (rw_q) begin
								sh_q      <= rd_now;          // RULE10
								sda_drv_q <= ~rd_now[7];
								bit_q     <= 3'h0;
								st_q      <= tofi2c_pkg::TOFI_RTX;
							end else begin
								sda_drv_q <= 1'h0;
								bit_q     <= 3'h0;
								st_q      <= tofi2c_pkg::TOFI_WRX;
							end
						end
					end
					tofi2c_pkg::TOFI_WACK: begin
						if (scl_fall) begin
							sda_drv_q <= 1'h0;
							bit_q     <= 3'h0;
							st_q      <= tofi2c_pkg::TOFI_WRX;
						end
					end
					tofi2c_pkg::TOFI_RTX: begin
						if (scl_fall) begin
							bit_q <= bit_q + 3'h1;
							if (bit_q == 3'h7) begin
								sda_drv_q <= 1'h0;            // RULE3
								idx_q     <= idx_q + 16'h1;   // RULE13
								st_q      <= tofi2c_pkg::TOFI_RACK;
							end else begin
								sda_drv_q <= ~sh_q[3'h6 - bit_q]; // RULE10
							end
						end
					end
					tofi2c_pkg::TOFI_RACK: begin
						if (scl_rise) begin
							sh_q <= rd_reg(idx_q);
							if (sda_s) begin
								st_q <= tofi2c_pkg::TOFI_IDLE; // RULE11 RULE12
							end
						end else if (scl_fall) begin
							sda_drv_q <= ~sh_q[7];
							bit_q     <= 3'h0;
							st_q      <= tofi2c_pkg::TOFI_RTX;
						end
					end
					default: begin
						sda_drv_q <= 1'h0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Register storage and ranging handshake
	// ------------------------------------------------------------
	wire   clr_hit   = wr_stb_q && wr_idx_q == tofi2c_pkg::IDX_INT_CLEAR && wr_dat_q[0];
	wire   start_hit = wr_stb_q && wr_idx_q == tofi2c_pkg::IDX_START;
	logic [31:0] rng_cnt_q;                    // Ranging timer
	wire   rng_done  = run_q && !ready_q && rng_cnt_q >= 32'(RANGE_CYCLES - 1);

	// Writes into storage
	always_ff @(posedge i_sys_clk) begin
		if (wr_stb_q && wr_idx_q < 16'(tofi2c_pkg::STORE_DEPTH)) begin
			mem_q[wr_idx_q[5:0]] <= wr_dat_q;          // RULE9
		end
	end

	// Ranging cycle held while ready stands
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			ready_q   <= 1'h0;
			run_q     <= 1'h0;
			rng_cnt_q <= 32'h0;
			res_q     <= 16'h0;
		end else if (!awake) begin
			ready_q   <= 1'h0;
			run_q     <= 1'h0;
			rng_cnt_q <= 32'h0;
		end else begin
			if (start_hit) begin
				run_q <= wr_dat_q[0];
			end
			if (rng_done) begin
				ready_q   <= 1'h1;                       // RULE15
				res_q     <= i_result;
				rng_cnt_q <= 32'h0;
			end else if (clr_hit) begin
				ready_q <= 1'h0;                         // RULE16
			end else if (run_q && !ready_q) begin
				rng_cnt_q <= rng_cnt_q + 32'h1;          // RULE18
			end
		end
	end

	// ------------------------------------------------------------
	// Open-drain outputs
	// ------------------------------------------------------------
	assign o_sda_out              = 1'h0;      // RULE14
	assign o_sda_oe               = sda_drv_q;
	assign o_scl_out              = 1'h0;
	assign o_scl_oe               = 1'h0;      // No clock stretching
	assign o_ready_irq_output_out = 1'h0;
	assign o_ready_irq_output_oe  = ready_q;   // RULE15
endmodule

//--- shared/tofi2c_pkg.sv
// Constants and types shared by the ranging sensor I2C target port
//
// Contract
// [RULE1] Target answers address byte 0x52 only
// [RULE2] Address LSB: zero write, one read
// [RULE3] Every byte followed by one acknowledge bit
// [RULE4] Data sampled on rising SCL edge
// [RULE5] Start/stop are SDA edges during high SCL
// [RULE6] Host opens with start, ends stop/restart
// [RULE7] Matching address acknowledged, direction bit latched
// [RULE8] Write carries 16-bit index after address
// [RULE9] Write bytes shifted in, acked, then stored
// [RULE10] Read loads register, shifts out on falling SCL
// [RULE11] Host acks read bytes, releases to stop
// [RULE12] Only host ends; target then releases SDA
// [RULE13] Index increments by one per data byte
// [RULE14] Target drives lines only low, never high
// [RULE15] Result ready pulls interrupt output low
// [RULE16] Ranging held while interrupt stays uncleared
// [RULE17] Host reads result then clears interrupt
// [RULE18] Ranging repeats every 33 ms period
// [RULE19] Shutdown low holds hardware standby, bus silent
// [RULE20] Boot within 1.2 ms then software standby
// [RULE21] Host releases shutdown only with bus idle
// [RULE22] Shutdown raised only with main supply on
// [RULE23] Multi-byte values MSB first, ascending addresses
// [RULE24] Read preceded by index-only write message
// [RULE25] Index retained across stop for next read
package tofi2c_pkg;
	// ------------------------------------------------------------
	// Bus constants
	// ------------------------------------------------------------
	localparam logic [6:0]  DEV_ADDR       = 7'h29;   // Seven-bit form of byte 0x52
	localparam int          INDEX_W        = 16;      // Register index width
	localparam int          DATA_W         = 8;       // Register width
	localparam int          SYS_CLK_HZ     = 10000000; // System clock rate
	// ------------------------------------------------------------
	// Timing constants
	// ------------------------------------------------------------
	localparam int          BOOT_TIME_US10 = 12;      // Boot time in tenths of ms (1.2 ms)
	localparam int          BOOT_CYCLES    = BOOT_TIME_US10 * (SYS_CLK_HZ / 10000);
	localparam int          RANGE_TIME_MS  = 33;      // Ranging operation time in ms
	localparam int          RANGE_CYCLES   = RANGE_TIME_MS * (SYS_CLK_HZ / 1000);
	// ------------------------------------------------------------
	// Mirror register map of the ranging side
	// ------------------------------------------------------------
	localparam logic [15:0] IDX_RESULT     = 16'h0000; // Result byte, MSB (two bytes)
	localparam logic [15:0] IDX_STATUS     = 16'h0002; // Bit0 shows ready
	localparam logic [15:0] IDX_INT_CLEAR  = 16'h0003; // Write bit0 to clear ready
	localparam logic [15:0] IDX_START      = 16'h0004; // Write bit0 to start ranging
	localparam int          STORE_DEPTH    = 64;      // Stored registers
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TOFI_IDLE  = 3'b000,   // Waiting for start
		TOFI_ADDR  = 3'b001,   // Receiving address byte
		TOFI_AACK  = 3'b011,   // Driving address acknowledge
		TOFI_WRX   = 3'b010,   // Receiving write byte
		TOFI_WACK  = 3'b110,   // Driving write acknowledge
		TOFI_RTX   = 3'b111,   // Sending read byte
		TOFI_RACK  = 3'b101    // Sampling host acknowledge
	} tofi_state_type;
	typedef enum logic [1:0] {
		TOFI_HW_STBY = 2'b00,  // Hardware standby state
		TOFI_BOOT    = 2'b01,  // Firmware boot state
		TOFI_SW_STBY = 2'b11   // Software standby state
	} tofi_power_type;
endpackage

//--- test/tofi2c_host_model.sv
// Bus master model that talks to the ranging sensor target
`timescale 1ns/10ps
module tofi2c_host_model (
	// Bus lines, high enable pulls low
	input  wire logic i_sda,
	output logic      o_scl_oe,
	output logic      o_sda_oe
);
	// ------
	// Bit timing: low 500 ns, high 300 ns
	// ------
	logic r;  // Last sampled bit
	initial begin
		o_scl_oe = 1'b0;
		o_sda_oe = 1'b0;
	end
	// One pulse; data moves late in low phase, clear of the sync lag
	task automatic bit_x(input logic b);
		o_scl_oe = 1'b1;
		#350 o_sda_oe = ~b;
		#150 o_scl_oe = 1'b0;
		#150 r = i_sda;
		#150;
	endtask
	// Start or repeated start; offset keeps edges off the clock
	task automatic start();
		#13 o_scl_oe = 1'b1;
		#350 o_sda_oe = 1'b0;
		#150 o_scl_oe = 1'b0;
		#300 o_sda_oe = 1'b1;
		#300;
	endtask
	// Stop: SDA rises while SCL high
	task automatic stop();
		o_scl_oe = 1'b1;
		#350 o_sda_oe = 1'b1;
		#150 o_scl_oe = 1'b0;
		#300 o_sda_oe = 1'b0;
		#500;
	endtask
	// Byte out, then the target's acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i]);
		bit_x(1'b1);
		ack = ~r;
	endtask
	// Byte in, then our acknowledge or release
	task automatic rbyte(input logic more, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1);
			d[i] = r;
		end
		bit_x(~more);
	endtask
endmodule

//--- test/tofi2c_target_properties.sv
// Concurrent checks on the ranging sensor target port pins
`timescale 1ns/10ps
module tofi2c_target_properties #(
	parameter int BOOT_CYCLES  = 20,  // Boot wait
	parameter int RANGE_CYCLES = 200  // Ranging period
) (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset,
	// Watched pins
	input  wire logic        i_shutdown_n_input,
	input  wire logic        i_scl,
	input  wire logic        o_scl_out,
	input  wire logic        o_scl_oe,
	input  wire logic        i_sda,
	input  wire logic        o_sda_out,
	input  wire logic        o_sda_oe,
	input  wire logic        o_ready_irq_output_out,
	input  wire logic        o_ready_irq_output_oe,
	input  wire logic [15:0] i_result,
	input  wire logic [1:0]  o_power_state
);
	// ------
	// Helper counters
	// ------
	logic [31:0] boot_q;  // Cycles spent booting
	logic [31:0] gap_q;   // Cycles with interrupt released
	// Count boot cycles and interrupt-free cycles
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			boot_q <= '0;
			gap_q  <= '0;
		end else begin
			boot_q <= (o_power_state == 2'b01) ? boot_q + 32'h1 : '0;
			gap_q  <= o_ready_irq_output_oe ? '0 : gap_q + 32'h1;
		end
	end
	// ------
	// Properties
	// ------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	sequence s_scl_high;
		(i_scl && i_shutdown_n_input)[*2];
	endsequence
	sequence s_standby_held;
		!i_shutdown_n_input[*5];
	endsequence
	chk_scl_never_driven: assert property (!o_scl_oe)
		else $error("target drives scl");
	chk_sda_low_only: assert property (o_sda_oe |-> !o_sda_out)
		else $error("sda driven high");
	chk_irq_low_only: assert property (o_ready_irq_output_oe |-> !o_ready_irq_output_out)
		else $error("interrupt driven high");
	chk_sda_stable_high: assert property (s_scl_high |-> $stable(o_sda_oe))
		else $error("sda changed while scl high");
	chk_standby_silent: assert property (s_standby_held |-> o_power_state == 2'b00
		&& !o_sda_oe && !o_ready_irq_output_oe) else $error("standby not silent");
	chk_bus_after_boot: assert property ((o_power_state != 2'b11
		&& $past(o_power_state) != 2'b11) |-> !o_sda_oe) else $error("bus answered early");
	chk_boot_order: assert property (($past(o_power_state) == 2'b00
		&& o_power_state != 2'b00) |-> o_power_state == 2'b01) else $error("boot skipped");
	chk_boot_length: assert property ((o_power_state == 2'b11
		&& $past(o_power_state) == 2'b01) |-> boot_q inside {[BOOT_CYCLES - 1:BOOT_CYCLES + 1]})
		else $error("boot length wrong");
	chk_irq_hold: assert property (disable iff (i_reset || !i_shutdown_n_input)
		$rose(o_ready_irq_output_oe) |-> o_ready_irq_output_oe[*8]) else $error("irq dropped");
	chk_range_period: assert property ($rose(o_ready_irq_output_oe)
		|-> gap_q >= RANGE_CYCLES - 4) else $error("ranging too early");
endmodule
bind tofi2c_target tofi2c_target_properties #(
	.BOOT_CYCLES(BOOT_CYCLES), .RANGE_CYCLES(RANGE_CYCLES)
) u_chk (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_shutdown_n_input(i_shutdown_n_input),
	.i_scl(i_scl), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe),
	.i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_ready_irq_output_out(o_ready_irq_output_out),
	.o_ready_irq_output_oe(o_ready_irq_output_oe),
	.i_result(i_result), .o_power_state(o_power_state)
);

//--- test/tofi2c_target_tb.sv
// Self-checking bench for the ranging sensor target port
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
$display("unexpected %s expected %h seen %h", n, e, a); end end
module tofi2c_target_tb;
	// ------
	// Signals
	// ------
	localparam int BOOT = 20;   // Shortened boot wait
	localparam int RNG  = 200;  // Shortened ranging period
	logic        sys_clk = 1'b0;
	logic        reset   = 1'b1;
	logic        shut_n  = 1'b1;  // Shutdown pin, active low
	logic [15:0] result  = 16'h0000;
	logic        h_scl_oe, h_sda_oe, scl_out, scl_oe, sda_out, sda_oe, irq_out, irq_oe;
	logic [1:0]  pwr;
	logic        ack;
	logic [7:0]  d, mem [4];
	logic [15:0] r1;
	logic [7:0]  q [$], e [$];  // Bytes to send, bytes expected
	int          error_cnt = 0;
	int          checked   = 0;
	wire         scl = ~(h_scl_oe | (scl_oe & ~scl_out));  // Pull-up wires
	wire         sda = ~(h_sda_oe | (sda_oe & ~sda_out));
	always #50 sys_clk = ~sys_clk;
	tofi2c_target #(.BOOT_CYCLES(BOOT), .RANGE_CYCLES(RNG)) DUT (
		.i_sys_clk(sys_clk), .i_reset(reset), .i_shutdown_n_input(shut_n),
		.i_scl(scl), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.o_ready_irq_output_out(irq_out), .o_ready_irq_output_oe(irq_oe),
		.i_result(result), .o_power_state(pwr)
	);
	tofi2c_host_model host (.i_sda(sda), .o_scl_oe(h_scl_oe), .o_sda_oe(h_sda_oe));
	// ------
	// Tasks
	// ------
	task automatic close_out();
		if (error_cnt == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Write message: index then queued data, no stop
	task automatic wr(input logic [15:0] idx);
		host.start();
		host.wbyte(8'h52, ack);
		`CHK("write addr ack", 1'b1, ack)
		host.wbyte(idx[15:8], ack);
		host.wbyte(idx[7:0], ack);
		`CHK("index ack", 1'b1, ack)
		foreach (q[i]) begin
			host.wbyte(q[i], ack);
			`CHK("data ack", 1'b1, ack)
		end
	endtask
	// Read message of n bytes against the expected queue
	task automatic rd(input int n);
		host.start();
		host.wbyte(8'h53, ack);
		`CHK("read addr ack", 1'b1, ack)
		for (int i = 0; i < n; i++) begin
			host.rbyte(i < n - 1, d);
			`CHK("read byte", e[i], d)
		end
		host.stop();
	endtask
	// Index-only write, repeated start, read
	task automatic rd_at(input logic [15:0] idx, input int n);
		q = {};
		wr(idx);
		rd(n);
	endtask
	// Boot span from release to software standby
	task automatic boot();
		int n;
		n = 0;
		while (pwr !== 2'b11 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("boot span", 1'b1, n >= BOOT && n <= BOOT + 4)
	endtask
	// Wait for the ready interrupt, bounded
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq_oe !== 1'b1 && n < RNG + 100) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("irq raised", 1'b1, irq_oe)
	endtask
	// ------
	// Main sequence and watchdog
	// ------
	initial begin
		#2000000;
		error_cnt++;
		close_out();
	end
	initial begin
		void'($urandom(32'h5560));
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		boot();
		for (int i = 0; i < 5; i++) begin
			d = (i == 0) ? 8'h50 : 8'($urandom);
			if (d[7:1] == 7'h29) d = d ^ 8'h80;
			host.start();
			host.wbyte(d, ack);
			`CHK("foreign ack", 1'b0, ack)
			host.stop();
		end
		foreach (mem[i]) mem[i] = 8'($urandom);
		q = '{mem[0], mem[1], mem[2], mem[3]};
		wr(16'h0010);
		host.stop();
		e = '{mem[0], mem[1], mem[2], mem[3]};
		rd_at(16'h0010, 4);
		q = '{mem[0]};
		wr(16'h0010);
		host.stop();
		e = '{mem[1], mem[2]};
		rd(2);
		@(posedge sys_clk);
		r1 = 16'($urandom);
		result <= r1;
		q = '{8'h01};
		wr(16'h0004);
		host.stop();
		wait_irq();
		@(posedge sys_clk);
		result <= ~r1;
		e = '{r1[15:8], r1[7:0], 8'h01};
		rd_at(16'h0000, 3);
		repeat (RNG + 20) @(negedge sys_clk);
		`CHK("irq held", 1'b1, irq_oe)
		e = '{r1[15:8], r1[7:0]};
		rd_at(16'h0000, 2);
		q = '{8'h01};
		wr(16'h0003);
		host.stop();
		`CHK("irq cleared", 1'b0, irq_oe)
		wait_irq();
		e = '{~r1[15:8], ~r1[7:0]};
		rd_at(16'h0000, 2);
		@(posedge sys_clk);
		shut_n <= 1'b0;
		repeat (5) @(negedge sys_clk);
		`CHK("standby power", 2'b00, pwr)
		`CHK("standby irq", 1'b0, irq_oe)
		host.start();
		host.wbyte(8'h52, ack);
		`CHK("standby ack", 1'b0, ack)
		host.stop();
		@(posedge sys_clk);
		shut_n <= 1'b1;
		boot();
		repeat (RNG + 20) @(negedge sys_clk);
		`CHK("run cleared", 1'b0, irq_oe)
		close_out();
	end
endmodule
